// File: common/csr_port_pkg.sv
package csr_port_pkg;

  // bus, counter and reset chain sizes
  localparam int ADDR_W       = 32;
  localparam int DATA_W       = 32;
  localparam int STRB_W       = 4;
  localparam int CNT_W        = 48;
  localparam int RESET_STAGES = 2;

  // default register counts
  localparam int CFG_COUNT  = 4;
  localparam int STAT_COUNT = 4;
  localparam int EVT_COUNT  = 3;

  // address map: two 512-byte pages, 32-byte register stride
  localparam logic [31:0] CFG_BASE       = 32'h0000_0000;
  localparam logic [31:0] STAT_PAGE_BASE = 32'h0000_0200;
  localparam logic [31:0] PAGE_BYTES     = 32'h0000_0200;
  localparam logic [31:0] REG_STRIDE     = 32'h0000_0020;
  localparam int          STRIDE_SHIFT   = 5;
  localparam logic [31:0] STAT_BASE      = 32'h0000_0200;
  localparam logic [31:0] TICK_OFFSET    = 32'h0000_0280;
  localparam logic [31:0] CNT_BASE       = 32'h0000_0300;
  localparam logic [31:0] CNT_MSB_OFFSET = 32'h0000_0004;

  // reset values
  localparam logic [31:0] CFG_RESET  = 32'h0000_0000;
  localparam logic [31:0] STAT_RESET = 32'h0000_0000;
  localparam logic [31:0] READ_ZERO  = 32'h0000_0000;

  // response codes
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_EXOKAY = 2'h1;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // address decode result
  typedef enum logic [2:0] {
    REGION_OUT    = 3'h0,
    REGION_HOLE   = 3'h1,
    REGION_CFG    = 3'h2,
    REGION_STAT   = 3'h3,
    REGION_TICK   = 3'h4,
    REGION_CNT_LO = 3'h5,
    REGION_CNT_HI = 3'h6
  } region_t;

  typedef struct packed {
    region_t    region;
    logic [7:0] index;
  } decode_t;

  // write address and data held until both are present
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] data;
    logic [3:0]  strb;
  } wr_req_t;

  typedef enum logic [1:0] {
    WR_COLLECT = 2'h1,
    WR_RESP    = 2'h2
  } wr_state_t;

  typedef enum logic [1:0] {
    RD_IDLE = 2'h1,
    RD_RESP = 2'h2
  } rd_state_t;

endpackage : csr_port_pkg

// File: verilog/reset_sync.sv
`timescale 1ns/1ns
module reset_sync #(
  parameter int STAGES = csr_port_pkg::RESET_STAGES
) (
  // clock and raw reset
  input  wire logic sys_clk,
  input  wire logic reset_n,
  // released reset
  output logic      rst_sync_n
);
  import csr_port_pkg::*;

  logic [STAGES-1:0] sync_q;

  // assert at once, release after the flop chain
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      sync_q <= '0;
    end else begin
      sync_q <= {sync_q[STAGES-2:0], 1'b1};
    end
  end

  assign rst_sync_n = sync_q[STAGES-1];

endmodule : reset_sync

// File: verilog/stat_counter.sv
`timescale 1ns/1ns
module stat_counter #(
  parameter int WIDTH = csr_port_pkg::CNT_W
) (
  // clock and resets
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  input  wire logic             sync_clr,
  // counting
  input  wire logic             count_event,
  input  wire logic             snapshot,
  // readable snapshot
  output logic [WIDTH-1:0]      snap_value
);
  import csr_port_pkg::*;

  logic [WIDTH-1:0] acc_q;
  logic [WIDTH-1:0] snap_q;
  logic             full;

  assign full = &acc_q;

  // accumulator saturates at all ones, restarts on snapshot
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_q <= '0;
    end else if (sync_clr) begin
      acc_q <= '0;
    end else if (snapshot) begin
      acc_q <= WIDTH'(count_event); // RQ11
    end else if (count_event && !full) begin
      acc_q <= acc_q + WIDTH'(1);
    end
  end

  // readable copy held until the next snapshot
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      snap_q <= '0;
    end else if (sync_clr) begin
      snap_q <= '0;
    end else if (snapshot) begin
      snap_q <= acc_q; // RQ11
    end
  end

  assign snap_value = snap_q;

endmodule : stat_counter

// File: verilog/eth_mac_axil_csr_port.sv
`timescale 1ns/1ns
// Function
// RQ1 - one clock; synchronous active-high reset returns the port to idle
// RQ2 - write address with valid is accepted by an address ready
// RQ3 - master supplies 32-bit write data with four byte-lane strobes
// RQ4 - write valid only while data and strobes are stable; device answers ready
// RQ5 - write outcome coded 00 okay, 01 exclusive okay, 10 slave, 11 decode error
// RQ6 - write response valid held until master takes it with ready
// RQ7 - read address with valid is accepted by read-address ready
// RQ8 - device drives 32-bit read data qualified by read valid
// RQ9 - read response code travels beside the read data
// RQ10 - master takes read data when ready and valid coincide
// RQ11 - one-cycle tick snapshots statistics and status and clears accumulators
// RQ12 - configuration page at 0x000, status and statistics page at 0x200
// RQ13 - registers sit on 32-byte aligned addresses; the counter MSB words sit at offset 0x4 instead
// RQ14 - holes in either page are reserved and answer with an error
// RQ15 - illegal addresses return slave error on the response channel; addresses from 0x400 up return decode error instead
// RQ16 - writing the tick register acts exactly like the tick input
// RQ17 - transfers happen only on valid and ready; valid holds until then
// RQ18 - write done only after address and data; one response per write
module eth_mac_axil_csr_port #(
  parameter int N_CFG  = csr_port_pkg::CFG_COUNT,
  parameter int N_STAT = csr_port_pkg::STAT_COUNT,
  parameter int N_EVT  = csr_port_pkg::EVT_COUNT
) (
  // clock and resets
  input  wire logic                                  sys_clk,
  input  wire logic                                  reset_n,
  input  wire logic                                  port_sync_reset,
  // statistics snapshot request
  input  wire logic                                  stats_snapshot_pulse,
  // write address channel
  input  wire logic [csr_port_pkg::ADDR_W-1:0]       awaddr,
  input  wire logic                                  awvalid,
  output logic                                       awready,
  // write data channel
  input  wire logic [csr_port_pkg::DATA_W-1:0]       wdata,
  input  wire logic [csr_port_pkg::STRB_W-1:0]       wstrb,
  input  wire logic                                  wvalid,
  output logic                                       wready,
  // write response channel
  output logic [1:0]                                 bresp,
  output logic                                       bvalid,
  input  wire logic                                  bready,
  // read address channel
  input  wire logic [csr_port_pkg::ADDR_W-1:0]       araddr,
  input  wire logic                                  arvalid,
  output logic                                       arready,
  // read data channel
  output logic [csr_port_pkg::DATA_W-1:0]            rdata,
  output logic [1:0]                                 rresp,
  output logic                                       rvalid,
  input  wire logic                                  rready,
  // configuration words toward the datapath
  output logic [N_CFG-1:0][csr_port_pkg::DATA_W-1:0] cfg_word,
  // live status words and counted events from the datapath
  input  wire logic [N_STAT-1:0][csr_port_pkg::DATA_W-1:0] status_word,
  input  wire logic [N_EVT-1:0]                      stat_event
);
  import csr_port_pkg::*;

  localparam int N_CNT = N_EVT + 1;

  // released reset copy
  logic rst_n;

  reset_sync #(
    .STAGES     (RESET_STAGES)
  ) u_reset_sync (
    .sys_clk    (sys_clk),
    .reset_n    (reset_n),
    .rst_sync_n (rst_n)
  );

  // decode of one byte address into a region and index
  function automatic decode_t decode_addr(input logic [31:0] a);
    decode_t     d;
    logic [31:0] off;
    logic [31:0] idx;
    d.region = REGION_HOLE;
    d.index  = '0;
    off      = '0;
    idx      = '0;
    if (a >= STAT_PAGE_BASE + PAGE_BYTES) begin
      d.region = REGION_OUT;
    end else if (a < STAT_PAGE_BASE) begin
      off = a - CFG_BASE;
      idx = off >> STRIDE_SHIFT;
      if ((off & (REG_STRIDE - 32'h0000_0001)) == '0 && idx < 32'(N_CFG)) begin // RQ13
        d.region = REGION_CFG;
        d.index  = idx[7:0];
      end
    end else if (a == TICK_OFFSET) begin
      d.region = REGION_TICK;
    end else if (a >= CNT_BASE) begin
      off = a - CNT_BASE;
      idx = off >> STRIDE_SHIFT;
      if (idx < 32'(N_CNT)) begin
        d.index = idx[7:0];
        if ((off & (REG_STRIDE - 32'h0000_0001)) == '0) begin
          d.region = REGION_CNT_LO;
        end else if ((off & (REG_STRIDE - 32'h0000_0001)) == CNT_MSB_OFFSET) begin
          d.region = REGION_CNT_HI;
        end
      end
    end else if (a >= STAT_BASE && a < TICK_OFFSET) begin
      off = a - STAT_BASE;
      idx = off >> STRIDE_SHIFT;
      if ((off & (REG_STRIDE - 32'h0000_0001)) == '0 && idx < 32'(N_STAT)) begin // RQ13
        d.region = REGION_STAT;
        d.index  = idx[7:0];
      end
    end
    return d;
  endfunction : decode_addr

  // response code for an access to a decoded region
  function automatic logic [1:0] access_resp(input region_t r, input logic is_write);
    logic [1:0] code;
    code = RESP_OKAY;
    unique case (r)
      REGION_OUT:    code = RESP_DECERR;
      REGION_HOLE:   code = RESP_SLVERR;
      REGION_STAT,
      REGION_CNT_LO,
      REGION_CNT_HI: code = is_write ? RESP_SLVERR : RESP_OKAY;
      REGION_CFG,
      REGION_TICK:   code = RESP_OKAY;
      default:       code = RESP_SLVERR;
    endcase
    return code;
  endfunction : access_resp

  // write path state
  wr_state_t   wr_state_q;
  logic        aw_full_q;
  logic        w_full_q;
  wr_req_t     wr_req_q;
  logic [1:0]  bresp_q;
  logic        aw_fire;
  logic        w_fire;
  logic        wr_go;
  decode_t     wr_dec;

  // read path state
  rd_state_t   rd_state_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;
  logic        ar_fire;
  decode_t     rd_dec;

  // statistics state
  logic                               tick_write;
  logic                               tick_now;
  logic [N_STAT-1:0][DATA_W-1:0]      stat_snap_q;
  logic [N_CFG-1:0][DATA_W-1:0]       cfg_q;
  logic [N_CNT-1:0][CNT_W-1:0]        cnt_snap;
  logic [N_CNT-1:0]                   cnt_event;

  // channel handshakes
  assign awready = (wr_state_q == WR_COLLECT) && !aw_full_q; // RQ2
  assign wready  = (wr_state_q == WR_COLLECT) && !w_full_q;
  assign aw_fire = awvalid && awready; // RQ17
  assign w_fire  = wvalid && wready; // RQ17
  assign wr_go   = (wr_state_q == WR_COLLECT) && aw_full_q && w_full_q; // RQ18
  assign wr_dec  = decode_addr(wr_req_q.addr);
  assign arready = (rd_state_q == RD_IDLE); // RQ7
  assign ar_fire = arvalid && arready; // RQ17
  assign rd_dec  = decode_addr(araddr);

  // write address, data and strobe holding registers, one driver for the struct
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      wr_req_q  <= '0;
    end else if (port_sync_reset) begin // RQ1
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      wr_req_q  <= '0;
    end else begin
      if (aw_fire) begin
        aw_full_q     <= 1'b1; // RQ2
        wr_req_q.addr <= awaddr;
      end else if (wr_go) begin
        aw_full_q <= 1'b0;
      end
      if (w_fire) begin
        w_full_q      <= 1'b1; // RQ4
        wr_req_q.data <= wdata;
        wr_req_q.strb <= wstrb; // RQ3
      end else if (wr_go) begin
        w_full_q <= 1'b0;
      end
    end
  end

  // write sequencing and single response
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_state_q <= WR_COLLECT;
      bresp_q    <= RESP_OKAY;
    end else if (port_sync_reset) begin
      wr_state_q <= WR_COLLECT;
      bresp_q    <= RESP_OKAY;
    end else begin
      unique case (wr_state_q)
        WR_COLLECT: begin
          if (wr_go) begin
            wr_state_q <= WR_RESP; // RQ18
            bresp_q    <= access_resp(wr_dec.region, 1'b1); // RQ5 RQ14 RQ15
          end
        end
        WR_RESP: begin
          if (bready) begin
            wr_state_q <= WR_COLLECT; // RQ6
          end
        end
        default: wr_state_q <= WR_COLLECT;
      endcase
    end
  end

  assign bvalid = (wr_state_q == WR_RESP); // RQ6
  assign bresp  = bresp_q;

  // configuration registers with byte-lane writes
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_q <= {N_CFG{CFG_RESET}};
    end else if (port_sync_reset) begin
      cfg_q <= {N_CFG{CFG_RESET}};
    end else if (wr_go && wr_dec.region == REGION_CFG) begin // RQ12
      for (int b = 0; b < STRB_W; b++) begin
        if (wr_req_q.strb[b]) begin
          cfg_q[wr_dec.index][b*8 +: 8] <= wr_req_q.data[b*8 +: 8]; // RQ3
        end
      end
    end
  end

  assign cfg_word = cfg_q;

  // snapshot from the pin or from a tick register write
  assign tick_write = wr_go && (wr_dec.region == REGION_TICK); // RQ16
  assign tick_now   = stats_snapshot_pulse || tick_write; // RQ11

  // status words frozen at each snapshot
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      stat_snap_q <= {N_STAT{STAT_RESET}};
    end else if (port_sync_reset) begin
      stat_snap_q <= {N_STAT{STAT_RESET}};
    end else if (tick_now) begin
      stat_snap_q <= status_word; // RQ11
    end
  end

  // counter 0 counts clock cycles between snapshots
  assign cnt_event = {stat_event, 1'b1};

  for (genvar c = 0; c < N_CNT; c++) begin : g_cnt
    stat_counter #(
      .WIDTH       (CNT_W)
    ) u_stat_counter (
      .sys_clk     (sys_clk),
      .rst_n       (rst_n),
      .sync_clr    (port_sync_reset),
      .count_event (cnt_event[c]),
      .snapshot    (tick_now),
      .snap_value  (cnt_snap[c])
    );
  end

  // read sequencing with registered data and response
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_state_q <= RD_IDLE;
      rdata_q    <= READ_ZERO;
      rresp_q    <= RESP_OKAY;
    end else if (port_sync_reset) begin
      rd_state_q <= RD_IDLE;
      rdata_q    <= READ_ZERO;
      rresp_q    <= RESP_OKAY;
    end else begin
      unique case (rd_state_q)
        RD_IDLE: begin
          if (ar_fire) begin
            rd_state_q <= RD_RESP;
            rresp_q    <= access_resp(rd_dec.region, 1'b0); // RQ9 RQ14 RQ15
            unique case (rd_dec.region)
              REGION_CFG:    rdata_q <= cfg_q[rd_dec.index]; // RQ8
              REGION_STAT:   rdata_q <= stat_snap_q[rd_dec.index];
              REGION_CNT_LO: rdata_q <= cnt_snap[rd_dec.index][31:0];
              REGION_CNT_HI: rdata_q <= {16'h0000, cnt_snap[rd_dec.index][CNT_W-1:32]};
              default:       rdata_q <= READ_ZERO;
            endcase
          end
        end
        RD_RESP: begin
          if (rready) begin
            rd_state_q <= RD_IDLE; // RQ10
          end
        end
        default: rd_state_q <= RD_IDLE;
      endcase
    end
  end

  assign rvalid = (rd_state_q == RD_RESP); // RQ8
  assign rdata  = rdata_q;
  assign rresp  = rresp_q;

endmodule : eth_mac_axil_csr_port

// File: bench/csr_port_props.sv
`timescale 1ns/1ns
module csr_port_props
  import csr_port_pkg::*;
(
  // clock and resets
  input wire logic        sys_clk,
  input wire logic        reset_n,
  input wire logic        port_sync_reset,
  // write channels
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic [1:0]  bresp,
  input wire logic        bvalid,
  input wire logic        bready,
  // read channels
  input wire logic [31:0] araddr,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0]  rresp,
  input wire logic        rvalid,
  input wire logic        rready
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n || port_sync_reset);
  // handshake steps
  sequence s_wr_both; awvalid && awready && wvalid && wready; endsequence
  sequence s_rd_take; arvalid && arready; endsequence
  sequence s_bad_rd;
    s_rd_take ##0 (araddr < 32'h0000_0400) ##0 (araddr[4:0] != 5'h00) ##0 (araddr[4:0] != 5'h04);
  endsequence
  a_b_holds: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");
  a_r_holds: assert property (rvalid && !rready |=> rvalid && $stable({rdata, rresp}))
    else $error("read data dropped early");
  a_rd_latency: assert property (s_rd_take |=> rvalid)
    else $error("read data late");
  a_ar_refused: assert property (rvalid |-> !arready)
    else $error("read address taken while busy");
  a_r_done: assert property (rvalid && rready |=> !rvalid)
    else $error("read data repeated");
  a_wr_resp: assert property (s_wr_both |=> !bvalid ##1 bvalid)
    else $error("write response late");
  a_b_refuses: assert property (bvalid |-> !awready && !wready)
    else $error("write taken while response pending");
  a_no_exokay: assert property (bvalid |-> bresp != RESP_EXOKAY)
    else $error("exclusive okay on write");
  a_hole_read: assert property (s_bad_rd |=> rresp == RESP_SLVERR && rdata == READ_ZERO)
    else $error("hole read not refused");
  a_decode_err: assert property (s_rd_take ##0 araddr >= 32'h0000_0400 |=> rresp == RESP_DECERR)
    else $error("outside read not decode error");
endmodule : csr_port_props

bind eth_mac_axil_csr_port csr_port_props u_props (
  .sys_clk(sys_clk), .reset_n(reset_n), .port_sync_reset(port_sync_reset),
  .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready),
  .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
  .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
  .rvalid(rvalid), .rready(rready)
);

// File: bench/axil_master_model.sv
`timescale 1ns/1ns
module axil_master_model (
  // clock
  input  wire logic   sys_clk,
  // write channels
  output logic [31:0] awaddr = '0,
  output logic        awvalid = 1'b0,
  input  wire logic   awready,
  output logic [31:0] wdata = '0,
  output logic [3:0]  wstrb = '0,
  output logic        wvalid = 1'b0,
  input  wire logic   wready,
  input  wire logic   bvalid,
  output logic        bready = 1'b0,
  // read channels
  output logic [31:0] araddr = '0,
  output logic        arvalid = 1'b0,
  input  wire logic   arready,
  input  wire logic   rvalid,
  output logic        rready = 1'b0
);
  // one write, both halves held until each is taken
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s);
    logic ad = 1'b0;
    logic dd = 1'b0;
    @(posedge sys_clk);
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= d;
    wstrb   <= s;
    wvalid  <= 1'b1;
    while (!(ad && dd)) begin
      @(posedge sys_clk);
      if (!ad && awready) begin
        ad = 1'b1;
        awvalid <= 1'b0;
        awaddr  <= ~a;
      end
      if (!dd && wready) begin
        dd = 1'b1;
        wvalid <= 1'b0;
        wdata  <= ~d;
        wstrb  <= ~s;
      end
    end
    repeat ($urandom_range(2)) @(posedge sys_clk);
    bready <= 1'b1;
    do @(posedge sys_clk); while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask : wr
  // one read, data taken with a random stall
  task automatic rd(input logic [31:0] a);
    @(posedge sys_clk);
    araddr  <= a;
    arvalid <= 1'b1;
    do @(posedge sys_clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    araddr  <= ~a;
    repeat ($urandom_range(2)) @(posedge sys_clk);
    rready <= 1'b1;
    do @(posedge sys_clk); while (rvalid !== 1'b1);
    rready <= 1'b0;
  endtask : rd
endmodule : axil_master_model

// File: bench/eth_mac_axil_csr_port_tb.sv
`timescale 1ns/1ns
module eth_mac_axil_csr_port_tb;
  import csr_port_pkg::*;
  // clock, resets and datapath stimulus
  logic                           sys_clk = 1'b0;
  logic                           reset_n = 1'b0;
  logic                           port_sync_reset = 1'b0;
  logic                           stats_snapshot_pulse = 1'b0;
  logic [STAT_COUNT-1:0][31:0]    status_word = '0;
  logic [EVT_COUNT-1:0]           stat_event = '0;
  // bus wires and block outputs
  logic [31:0]                    awaddr, wdata, araddr, rdata;
  logic [3:0]                     wstrb;
  logic [1:0]                     bresp, rresp;
  logic                           awvalid, awready, wvalid, wready, bvalid, bready;
  logic                           arvalid, arready, rvalid, rready;
  logic [CFG_COUNT-1:0][31:0]     cfg_word;
  // expected results and bookkeeping
  logic [1:0]                     exp_b[$];
  logic [33:0]                    exp_r[$];
  logic [31:0]                    v[4];
  logic [31:0]                    d;
  logic [3:0]                     s;
  int                             errors = 0;
  int                             checks = 0;
  int                             cycles = 0;
  int                             k;

  always #25 sys_clk = ~sys_clk;

  eth_mac_axil_csr_port u_dut (
    .sys_clk(sys_clk), .reset_n(reset_n), .port_sync_reset(port_sync_reset),
    .stats_snapshot_pulse(stats_snapshot_pulse), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .cfg_word(cfg_word), .status_word(status_word), .stat_event(stat_event)
  );
  axil_master_model u_mst (
    .sys_clk(sys_clk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rvalid(rvalid), .rready(rready)
  );

  task automatic chk_resp(input logic [1:0] e, input logic [1:0] g);
    checks++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] bresp exp %h got %h", e, g);
    end
  endtask : chk_resp
  task automatic chk_word(input string n, input logic [33:0] e, input logic [33:0] g);
    checks++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask : chk_word
  task automatic wr(input logic [31:0] a, input logic [31:0] dd, input logic [3:0] st,
                    input logic [1:0] r);
    exp_b.push_back(r);
    u_mst.wr(a, dd, st);
  endtask : wr
  task automatic rd(input logic [31:0] a, input logic [33:0] e);
    exp_r.push_back(e);
    u_mst.rd(a);
  endtask : rd
  task automatic pulse();
    @(posedge sys_clk);
    stats_snapshot_pulse <= 1'b1;
    @(posedge sys_clk);
    stats_snapshot_pulse <= 1'b0;
  endtask : pulse
  task automatic wrap_up();
    if (errors == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : wrap_up

  // response monitor and hang guard
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (bvalid && bready) chk_resp(exp_b.size() ? exp_b.pop_front() : 2'bxx, bresp);
    if (rvalid && rready)
      chk_word("read", exp_r.size() ? exp_r.pop_front() : 'x, {rdata, rresp});
    if (cycles == 6000) begin
      errors++;
      wrap_up();
    end
  end

  // main sequence
  initial begin
    d = $urandom(32'h510f282d);
    repeat (4) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    for (int i = 0; i < CFG_COUNT; i++) begin
      v[i] = $urandom;
      wr(CFG_BASE + REG_STRIDE * i, v[i], 4'hf, RESP_OKAY);
    end
    d = $urandom;
    s = $urandom;
    wr(CFG_BASE + REG_STRIDE, d, s, RESP_OKAY);
    for (int b = 0; b < 4; b++)
      if (s[b]) v[1][8*b+:8] = d[8*b+:8];
    // refused writes, config reads, refused reads, tick read
    wr(32'h0000_0010, $urandom, 4'hf, RESP_SLVERR);
    wr(STAT_BASE, $urandom, 4'hf, RESP_SLVERR);
    wr(32'h0000_0404, $urandom, 4'hf, RESP_DECERR);
    for (int i = 0; i < CFG_COUNT; i++)
      rd(CFG_BASE + REG_STRIDE * i, {v[i], RESP_OKAY});
    rd(32'h0000_0008, {READ_ZERO, RESP_SLVERR});
    rd(32'h0000_0380, {READ_ZERO, RESP_SLVERR});
    rd(32'h0000_0400, {READ_ZERO, RESP_DECERR});
    rd(TICK_OFFSET, {READ_ZERO, RESP_OKAY});
    chk_word("cfg_word", {2'b00, v[0]}, {2'b00, cfg_word[0]});
    // status frozen by the pulse
    for (int i = 0; i < STAT_COUNT; i++)
      v[i] = $urandom;
    status_word <= {v[3], v[2], v[1], v[0]};
    pulse();
    status_word <= ~{v[3], v[2], v[1], v[0]};
    for (int i = 0; i < STAT_COUNT; i++)
      rd(STAT_BASE + REG_STRIDE * i, {v[i], RESP_OKAY});
    // events counted up to a tick write
    k = $urandom_range(20, 1);
    @(posedge sys_clk);
    stat_event <= '1;
    repeat (k) @(posedge sys_clk);
    stat_event <= '0;
    wr(TICK_OFFSET, $urandom, 4'hf, RESP_OKAY);
    for (int j = 1; j <= EVT_COUNT; j++) begin
      rd(CNT_BASE + REG_STRIDE * j, {k[31:0], RESP_OKAY});
      rd(CNT_BASE + REG_STRIDE * j + CNT_MSB_OFFSET, {READ_ZERO, RESP_OKAY});
    end
    // cycle count over a known gap, event counter 1 cleared
    pulse();
    repeat (10) @(posedge sys_clk);
    pulse();
    rd(CNT_BASE, {32'h0000_000c, RESP_OKAY});
    rd(CNT_BASE + REG_STRIDE, {READ_ZERO, RESP_OKAY});
    // synchronous reset clears the config words
    @(posedge sys_clk);
    port_sync_reset <= 1'b1;
    @(posedge sys_clk);
    port_sync_reset <= 1'b0;
    rd(CFG_BASE, {CFG_RESET, RESP_OKAY});
    @(posedge sys_clk);
    chk_word("cfg_word", {2'b00, CFG_RESET}, {2'b00, cfg_word[1]});
    wrap_up();
  end
endmodule : eth_mac_axil_csr_port_tb
